// File: hdl/ipnc_ctrl.sv
// interrupt priority nesting controller with apb register access
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - stack holds four 2-bit masks; newest in bits 7:6, oldest 1:0
// - each level register holds four sources, source n in bits 2n+1:2n
// - level register count is a parameter: 4, 6, 8, 10 or 12
// - levels are 0 to 3, three highest
// - level registers always readable/writable; gating uses live contents
// - enabled: request passes only when its level is at least the mask
// - in stop3 the comparison uses mask zero
// - disabled: requests pass straight through
// - levels only gate; the cpu arbitrates among passed requests
// - enabled: vector fetch loads mask with the fetched source's level
// - fetch pushes old mask into top entry, others shift down
// - writing one to pull bit restores mask from top entry
// - stack retains at most four saved masks
// - full flag set when last entry filled; recomputed each push/pull
// - empty flag set when no valid entry; recomputed each push/pull
// - mask sits in control bits 1:0 and decides gating except in stop3
// - masking external pin request leaves pin level readable for branches
// - disabled: vector fetches leave the stack unchanged
// - push while full discards the bottom entry
// - pull shifts toward top and zero-fills bits 1:0
// - pull with mask write while enabled: pulled value wins
module ipnc_ctrl #(
  parameter int unsigned NUM_LVL_REGS = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire ipnc_pkg::ipnc_apb_req_t apb_req,
  output ipnc_pkg::ipnc_apb_rsp_t apb_rsp,
  input wire logic [NUM_LVL_REGS*4-1:0] source_request_in,
  input wire logic vector_fetch_strobe,
  input wire logic [5:0] vector_source,
  input wire logic stop3_mode,
  input wire logic ext_pin_in,
  output logic [NUM_LVL_REGS*4-1:0] cpu_request_out,
  output logic ext_pin_level
);
  localparam int unsigned NSRC = NUM_LVL_REGS * ipnc_pkg::ipnc_src_per_reg;

  initial begin
    if (!(NUM_LVL_REGS inside {4, 6, 8, 10, 12})) begin
      $error("level register count must be 4, 6, 8, 10 or 12");
    end
  end

  typedef struct packed {
    logic prio_gate_on;
    logic [1:0] current_mask;
    logic [7:0] mask_history_stack;
    logic [2:0] depth;
    logic [NUM_LVL_REGS*8-1:0] priority_levels;
    logic [NSRC-1:0] cpu_request_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_meta;
    logic pin_sync;
  } ipnc_state_t;

  ipnc_state_t st;
  ipnc_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  logic setup;
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_stack;
  logic hit_pins;
  logic hit_lvl;
  logic [31:0] lvl_idx;
  logic [1:0] eff_mask;
  logic [1:0] fetch_level;
  logic do_push;
  logic do_pull;

  // answer in the first access cycle; a write lands on the edge that samples pready
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && st.pready;
  assign rd_en = setup && !apb_req.pwrite;
  assign hit_ctrl = apb_req.paddr[7:0] == ipnc_pkg::ipnc_off_ctrl;
  assign hit_stack = apb_req.paddr[7:0] == ipnc_pkg::ipnc_off_stack;
  assign hit_pins = apb_req.paddr[7:0] == ipnc_pkg::ipnc_off_pins;
  assign lvl_idx = 32'(apb_req.paddr[7:2]) - 32'(ipnc_pkg::ipnc_off_lvl_base[7:2]);
  assign hit_lvl = apb_req.paddr[7:0] >= ipnc_pkg::ipnc_off_lvl_base &&
                   lvl_idx < NUM_LVL_REGS && apb_req.paddr[1:0] == 2'h0 &&
                   apb_req.paddr[31:8] == 24'h0;
  // stop3 bypass does not touch the stored mask
  assign eff_mask = stop3_mode ? ipnc_pkg::ipnc_stop3_mask : st.current_mask;
  assign fetch_level = (32'(vector_source) < NSRC) ?
                       st.priority_levels[vector_source*2 +: 2] : 2'h0;
  assign do_push = vector_fetch_strobe && st.prio_gate_on;
  assign do_pull = wr_en && hit_ctrl && apb_req.pwrite &&
                   apb_req.pwdata[ipnc_pkg::ipnc_bit_pull];

  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.pin_meta = ext_pin_in;
    next_st.pin_sync = st.pin_meta;
    // gating: live level contents, no reordering
    for (int i = 0; i < NSRC; i++) begin
      if (st.prio_gate_on) begin
        next_st.cpu_request_out[i] = source_request_in[i] &&
          (st.priority_levels[i*2 +: 2] >= eff_mask);
      end else begin
        next_st.cpu_request_out[i] = source_request_in[i];
      end
    end
    // register writes
    if (wr_en && hit_ctrl) begin
      next_st.prio_gate_on = apb_req.pwdata[ipnc_pkg::ipnc_bit_enable];
      next_st.current_mask = apb_req.pwdata[ipnc_pkg::ipnc_mask_lsb +: 2];
    end
    if (wr_en && hit_lvl) begin
      next_st.priority_levels[lvl_idx*8 +: 8] = apb_req.pwdata[7:0];
    end
    // pull wins over written mask; a fetch in the same cycle wins over both
    if (do_pull) begin
      next_st.current_mask = st.mask_history_stack[7:6];
      next_st.mask_history_stack = {st.mask_history_stack[5:0], 2'h0};
      next_st.depth = (st.depth == 3'h0) ? 3'h0 : st.depth - 3'h1;
    end
    if (do_push) begin
      next_st.current_mask = fetch_level;
      // bottom entry falls out when full
      next_st.mask_history_stack = {st.current_mask,
                                    st.mask_history_stack[7:2]};
      next_st.depth = (st.depth == ipnc_pkg::ipnc_depth) ? st.depth :
                      st.depth + 3'h1;
    end
    if (setup && apb_req.pwrite) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !(hit_ctrl || hit_lvl || hit_stack || hit_pins);
    end
    if (rd_en) begin
      next_st.prdata = 32'h0;
      if (hit_ctrl) begin
        next_st.prdata[ipnc_pkg::ipnc_bit_enable] = st.prio_gate_on;
        next_st.prdata[ipnc_pkg::ipnc_bit_empty] = st.depth == 3'h0;
        next_st.prdata[ipnc_pkg::ipnc_bit_full] = st.depth == ipnc_pkg::ipnc_depth;
        next_st.prdata[1:0] = st.current_mask;
      end else if (hit_stack) begin
        next_st.prdata[7:0] = st.mask_history_stack;
      end else if (hit_pins) begin
        next_st.prdata[0] = st.pin_sync;
      end else if (hit_lvl) begin
        next_st.prdata[7:0] = st.priority_levels[lvl_idx*8 +: 8];
      end
      next_st.pslverr = !(hit_ctrl || hit_lvl || hit_stack || hit_pins);
      next_st.pready = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.prio_gate_on <= 1'b0;
      st.current_mask <= ipnc_pkg::ipnc_mask_rst;
      st.mask_history_stack <= ipnc_pkg::ipnc_stack_rst;
      st.depth <= 3'h0;
      st.priority_levels <= {NUM_LVL_REGS{ipnc_pkg::ipnc_lvl_rst}};
      st.cpu_request_out <= '0;
      st.prdata <= 32'h0;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.pin_meta <= 1'b0;
      st.pin_sync <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign apb_rsp.prdata = st.prdata;
  assign apb_rsp.pready = st.pready;
  assign apb_rsp.pslverr = st.pslverr;
  assign cpu_request_out = st.cpu_request_out;
  assign ext_pin_level = st.pin_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fetch_on_s;
    vector_fetch_strobe && st.prio_gate_on;
  endsequence

  push_top_a: assert property (fetch_on_s |=> st.mask_history_stack[7:6] ==
      $past(st.current_mask)) else $error("push missed top entry");
  push_shift_a: assert property (fetch_on_s |=> st.mask_history_stack[5:0] ==
      $past(st.mask_history_stack[7:2])) else $error("push shift wrong");
  fetch_load_a: assert property (fetch_on_s |=> st.current_mask == $past(fetch_level))
      else $error("mask not loaded on fetch");
  off_hold_a: assert property (vector_fetch_strobe && !st.prio_gate_on && !do_pull |=>
      $stable(st.mask_history_stack)) else $error("stack moved while off");
  pull_top_a: assert property (do_pull && !do_push |=> st.current_mask ==
      $past(st.mask_history_stack[7:6]) && st.mask_history_stack[1:0] == 2'h0)
      else $error("pull wrong");
  depth_cap_a: assert property (st.depth <= ipnc_pkg::ipnc_depth)
      else $error("depth over four");
  bypass_a: assert property (!st.prio_gate_on |=> cpu_request_out ==
      $past(source_request_in)) else $error("bypass failed");
  stop3_a: assert property (st.prio_gate_on && stop3_mode ##1 st.prio_gate_on |->
      cpu_request_out == $past(source_request_in)) else $error("stop3 gated");
  full_a: assert property (fetch_on_s ##1 fetch_on_s ##1 fetch_on_s ##1 fetch_on_s
      ##1 !do_pull |-> st.depth == ipnc_pkg::ipnc_depth) else $error("not full");
  apb_ans_a: assert property (setup |=> st.pready) else $error("no answer");

  ////////////////////////////////////////////////////////////////////////////////
  // stack and flag checks
  sequence pull_only_s;
    do_pull && !do_push;
  endsequence

  sequence ctrl_read_s;
    rd_en && hit_ctrl;
  endsequence

  sequence lvl_write_s;
    wr_en && hit_lvl;
  endsequence

  pull_shift_a: assert property (pull_only_s |=>
      st.mask_history_stack == {$past(st.mask_history_stack[5:0]), 2'h0})
      else $error("pull shift wrong");

  pull_count_a: assert property (pull_only_s |=>
      st.depth == (($past(st.depth) == 3'h0) ? 3'h0 : $past(st.depth) - 3'h1))
      else $error("pull count wrong");

  push_count_a: assert property (fetch_on_s |=>
      st.depth == (($past(st.depth) == ipnc_pkg::ipnc_depth) ? ipnc_pkg::ipnc_depth :
      $past(st.depth) + 3'h1)) else $error("push count wrong");

  full_keep_a: assert property (fetch_on_s && st.depth == ipnc_pkg::ipnc_depth |=>
      st.depth == ipnc_pkg::ipnc_depth) else $error("full count moved");

  pull_wins_a: assert property (do_pull && !do_push && st.prio_gate_on |=>
      st.current_mask == $past(st.mask_history_stack[7:6]))
      else $error("written mask beat pull");

  write_nopush_a: assert property (wr_en && hit_ctrl && !do_pull && !do_push |=>
      $stable(st.mask_history_stack)) else $error("mask write pushed");

  stack_hold_a: assert property (!do_push && !do_pull |=>
      $stable(st.mask_history_stack)) else $error("stack moved idle");

  ////////////////////////////////////////////////////////////////////////////////
  // register read and write checks
  empty_read_a: assert property (ctrl_read_s |=>
      st.prdata[ipnc_pkg::ipnc_bit_empty] == ($past(st.depth) == 3'h0))
      else $error("empty flag wrong");

  full_read_a: assert property (ctrl_read_s |=>
      st.prdata[ipnc_pkg::ipnc_bit_full] == ($past(st.depth) == ipnc_pkg::ipnc_depth))
      else $error("full flag wrong");

  mask_read_a: assert property (ctrl_read_s |=>
      st.prdata[1:0] == $past(st.current_mask))
      else $error("mask read wrong");

  pull_read_a: assert property (ctrl_read_s |=>
      !st.prdata[ipnc_pkg::ipnc_bit_pull])
      else $error("pull bit read back");

  stack_read_a: assert property (rd_en && hit_stack |=>
      st.prdata[7:0] == $past(st.mask_history_stack))
      else $error("stack read wrong");

  upper_zero_a: assert property (rd_en |=> st.prdata[31:8] == 24'h0)
      else $error("upper read bits set");

  level_write_a: assert property (lvl_write_s |=>
      st.priority_levels[$past(lvl_idx)*8 +: 8] == $past(apb_req.pwdata[7:0]))
      else $error("level write lost");

  levels_hold_a: assert property (!(wr_en && hit_lvl) |=>
      $stable(st.priority_levels)) else $error("levels moved");

  mask_write_a: assert property (wr_en && hit_ctrl && !do_pull && !do_push |=>
      st.current_mask == $past(apb_req.pwdata[1:0]))
      else $error("mask write lost");

  enable_write_a: assert property (wr_en && hit_ctrl |=>
      st.prio_gate_on == $past(apb_req.pwdata[ipnc_pkg::ipnc_bit_enable]))
      else $error("enable write lost");

  mask_hold_a: assert property (!do_push && !do_pull && !(wr_en && hit_ctrl) |=>
      $stable(st.current_mask)) else $error("mask moved idle");

  stop3_keep_a: assert property (stop3_mode && !do_push && !do_pull &&
      !(wr_en && hit_ctrl) |=> $stable(st.current_mask))
      else $error("stop3 changed mask");

  pready_pulse_a: assert property (st.pready |=> !st.pready)
      else $error("pready longer than one cycle");

  rdata_hold_a: assert property (st.pready |=> $stable(st.prdata))
      else $error("read data moved");

  slverr_map_a: assert property (setup && !(hit_ctrl || hit_lvl || hit_stack || hit_pins)
      |=> st.pslverr) else $error("unmapped access not refused");

  ////////////////////////////////////////////////////////////////////////////////
  // gating checks on source zero, then the pin sync check
  gate_block_a: assert property (st.prio_gate_on && !stop3_mode && source_request_in[0] &&
      st.priority_levels[1:0] < st.current_mask |=> !cpu_request_out[0])
      else $error("low level passed");

  gate_pass_a: assert property (st.prio_gate_on && source_request_in[0] &&
      st.priority_levels[1:0] >= st.current_mask |=> cpu_request_out[0])
      else $error("qualified request blocked");

  idle_low_a: assert property (!source_request_in[0] |=> !cpu_request_out[0])
      else $error("request invented");

  pin_track_a: assert property ($past(presetn) && $past(presetn, 2) |->
      ext_pin_level == $past(ext_pin_in, 2))
      else $error("pin level lost");
endmodule // ipnc_ctrl

// File: hdl/ipnc_pkg.sv
// package for the interrupt priority nesting controller: offsets, fields, carriers
package ipnc_pkg;
  localparam int unsigned ipnc_src_per_reg = 4;
  localparam int unsigned ipnc_lvl_w = 2;
  // byte offsets on the apb side
  localparam logic [7:0] ipnc_off_ctrl = 8'h00;
  localparam logic [7:0] ipnc_off_stack = 8'h04;
  localparam logic [7:0] ipnc_off_lvl_base = 8'h10;
  localparam logic [7:0] ipnc_off_pins = 8'h08;
  // control register field positions
  localparam int unsigned ipnc_bit_enable = 7;
  localparam int unsigned ipnc_bit_empty = 5;
  localparam int unsigned ipnc_bit_full = 4;
  localparam int unsigned ipnc_bit_pull = 3;
  localparam int unsigned ipnc_mask_lsb = 0;
  // reset values, stack depth and stop3 mask
  localparam logic [1:0] ipnc_mask_rst = 2'h0;
  localparam logic [7:0] ipnc_stack_rst = 8'h00;
  localparam logic [7:0] ipnc_lvl_rst = 8'h00;
  localparam logic [2:0] ipnc_depth = 3'h4;
  localparam logic [1:0] ipnc_stop3_mask = 2'h0;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ipnc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ipnc_apb_rsp_t;
endpackage

// File: test/ipnc_cpu_model.sv
// cpu side model: registers a fetch command into a vector fetch strobe one cycle later, as long as the command
module ipnc_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_cmd,
  input wire logic [5:0] fetch_src,
  output logic vector_fetch_strobe,
  output logic [5:0] vector_source
);
  timeunit 1ns;
  timeprecision 1ps;
  // index is only valid with the strobe, so it is scrambled in between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_fetch_strobe <= 1'h0;
      vector_source <= 6'h00;
    end else begin
      vector_fetch_strobe <= fetch_cmd;
      vector_source <= fetch_cmd ? fetch_src : ~vector_source;
    end
  end
endmodule // ipnc_cpu_model

// File: test/interrupt_priority_nesting_ctrl_test.sv
// self-checking bench for the priority nesting controller
module interrupt_priority_nesting_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] lvl;
    logic [7:0] ctrl;
    logic stop;
    logic [15:0] src;
    logic [15:0] exp;
  } ipnc_row_t;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  ipnc_pkg::ipnc_apb_req_t req = '0;
  ipnc_pkg::ipnc_apb_rsp_t rsp;
  logic [15:0] src = 16'h0000;
  logic stop3 = 1'h0;
  logic pin = 1'h0;
  logic fetch_cmd = 1'h0;
  logic [5:0] fetch_src = 6'h00;
  logic strobe;
  logic [5:0] vsrc;
  logic [15:0] out;
  logic pin_level;
  int n_errors = 0;
  int tests_run = 0;
  ipnc_row_t rows [6] = '{
    '{8'hE4, 8'h80, 1'h0, 16'h000F, 16'h000F},
    '{8'hE4, 8'h82, 1'h0, 16'h00FF, 16'h000C},
    '{8'hE4, 8'h83, 1'h0, 16'hFFFF, 16'h0008},
    '{8'h1B, 8'h83, 1'h0, 16'h000F, 16'h0001},
    '{8'h1B, 8'h83, 1'h1, 16'h00F0, 16'h00F0},
    '{8'h1B, 8'h03, 1'h0, 16'hA5A5, 16'hA5A5}};
  localparam logic [5:0] fsrc [5] = '{6'h03, 6'h02, 6'h00, 6'h01, 6'h03};
  localparam logic [7:0] fstk [5] = '{8'h40, 8'hD0, 8'hB4, 8'h2D, 8'h4B};
  localparam logic [7:0] fctl [5] = '{8'h83, 8'h82, 8'h80, 8'h91, 8'h93};
  localparam logic [7:0] pdat [4] = '{8'h8A, 8'h88, 8'h88, 8'h88};
  localparam logic [7:0] pstk [4] = '{8'h2C, 8'hB0, 8'hC0, 8'h00};
  localparam logic [7:0] pctl [4] = '{8'h81, 8'h80, 8'h82, 8'hA3};
  ////////////////////////////////////////////////////////////
  ipnc_ctrl #(.NUM_LVL_REGS(4)) dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .source_request_in(src), .vector_fetch_strobe(strobe),
    .vector_source(vsrc), .stop3_mode(stop3), .ext_pin_in(pin),
    .cpu_request_out(out), .ext_pin_level(pin_level));
  ipnc_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .fetch_cmd(fetch_cmd),
    .fetch_src(fetch_src), .vector_fetch_strobe(strobe), .vector_source(vsrc));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // pready read at the rising edge, before the slave's flops move
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
      output logic [31:0] q, output logic e);
    logic got;
    got = 1'h0;
    @(posedge pclk);
    req.paddr <= {24'h000000, a};
    req.pwrite <= w;
    req.pwdata <= {24'h000000, d};
    req.psel <= 1'h1;
    req.penable <= 1'h0;
    @(posedge pclk);
    req.penable <= 1'h1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge pclk);
      got = (rsp.pready === 1'h1);
    end
    if (!got) n_errors++;
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    xfer(a, 1'h1, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic err);
    logic [31:0] q;
    logic e;
    xfer(a, 1'h0, 8'h00, q, e);
    chk(q, {24'h000000, d});
    chk({31'h0, e}, {31'h0, err});
  endtask
  task automatic fetch(input logic [5:0] s);
    @(posedge pclk);
    fetch_cmd <= 1'h1;
    fetch_src <= s;
    @(posedge pclk);
    fetch_cmd <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic summarize();
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h00, 8'h20, 1'h0);
    rd(8'h04, 8'h00, 1'h0);
    rd(8'hFC, 8'h00, 1'h1);
    foreach (rows[i]) begin
      wr(8'h10, rows[i].lvl);
      wr(8'h00, rows[i].ctrl);
      stop3 <= rows[i].stop;
      src <= rows[i].src;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({16'h0000, out}, {16'h0000, rows[i].exp});
    end
    rd(8'h10, 8'h1B, 1'h0);
    wr(8'h10, 8'hE4);
    wr(8'h00, 8'h81);
    // fifth push overflows, bottom entry lost
    for (int i = 0; i < 5; i++) begin
      fetch(fsrc[i]);
      rd(8'h04, fstk[i], 1'h0);
      rd(8'h00, fctl[i], 1'h0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, pdat[i]);
      rd(8'h04, pstk[i], 1'h0);
      rd(8'h00, pctl[i], 1'h0);
    end
    wr(8'h00, 8'h00);
    fetch(6'h03);
    rd(8'h04, 8'h00, 1'h0);
    rd(8'h00, 8'h20, 1'h0);
    pin <= 1'h1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, pin_level}, 32'h00000001);
    rd(8'h08, 8'h01, 1'h0);
    summarize();
  end
endmodule // interrupt_priority_nesting_ctrl_test
